// ### rtl/vtx_pkg.sv
// Constants and types shared by the VPW frame transmit-end control
package vtx_pkg;
	// Register word offsets on the slave bus
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_DATA = 4'h4;
	localparam logic [3:0] OFS_SV = 4'h8;
	// Field positions in transmit_control_register
	localparam int CTL_MNC = 0;
	localparam int CTL_MC = 1;
	localparam int CTL_SI = 2;
	localparam int CTL_EOD = 3;
	localparam int CTL_POL = 4;
	localparam int CTL_W = 5;
	localparam logic [CTL_W-1:0] CTRL_RST = 5'h00;
	// State vector codes
	localparam logic [7:0] SV_NONE = 8'h00;
	localparam logic [7:0] SV_TX_BUFFER_EMPTY_FLAG = 8'h10;
	localparam logic [7:0] SV_ARB = 8'h14;
	// CRC-8 seed and polynomial
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h1d;
	// Bit slot timing
	localparam int CLK_MHZ = 200;
	localparam int BIT_US = 64;
	localparam int BIT_CYC = BIT_US * CLK_MHZ;
	localparam logic [3:0] LEN_BIT = 4'h1;
	localparam logic [3:0] LEN_BYTE = 4'h8;
	localparam logic [3:0] LEN_ONES = 4'h2;
	localparam logic [3:0] LATE_BITS = 4'h2;
	localparam logic [7:0] ONES_DATA = 8'hff;
	typedef enum logic [1:0] {SYM_BIT, SYM_BYTE, SYM_EOD, SYM_ONES} vtx_sym_e;
endpackage

// ### rtl/vtx_eng_if.sv
// Handshake between the framing sequencer and the bit engine
`timescale 1ns/10ps
interface vtx_eng_if;
	logic start;
	logic abort;
	logic bit_en;
	vtx_pkg::vtx_sym_e sym;
	logic [7:0] data;
	logic busy;
	logic done;
	logic lost;
	logic lost_late;
	logic first_bit;
	modport ctl(output start, abort, bit_en, sym, data,
		input busy, done, lost, lost_late, first_bit);
	modport eng(input start, abort, bit_en, sym, data,
		output busy, done, lost, lost_late, first_bit);
endinterface

// ### rtl/vtx_crc8.sv
// Running CRC-8 over transmitted bytes
`timescale 1ns/10ps
module vtx_crc8 (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Control and data
	input wire logic clr_i,
	input wire logic upd_i,
	input wire logic [7:0] data_i,
	output logic [7:0] crc_o
);
	logic [7:0] crc_q;
	logic [7:0] next_crc;

	// Bitwise MSB-first division, one byte per update
	always_comb begin
		next_crc = crc_q;
		for (int i = 7; i >= 0; i--) begin
			if (next_crc[7] ^ data_i[i]) begin
				next_crc = {next_crc[6:0], 1'b0} ^ vtx_pkg::CRC_POLY;
			end else begin
				next_crc = {next_crc[6:0], 1'b0};
			end
		end
	end

	// Seeded at each frame or response start
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			crc_q <= vtx_pkg::CRC_INIT;
		end else if (clr_i) begin
			crc_q <= vtx_pkg::CRC_INIT;
		end else if (upd_i) begin
			crc_q <= next_crc;
		end
	end

	// Transmitted value is the complement
	assign crc_o = ~crc_q;
endmodule

// ### rtl/vtx_bit_engine.sv
// Serialises one symbol per start and watches arbitration
`timescale 1ns/10ps
module vtx_bit_engine (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Bus level seen back
	input wire logic rx_bit_i,
	// Sequencer side
	vtx_eng_if.eng eng,
	// Line side
	output logic tx_drive_o,
	output logic tx_bit_o
);
	logic [7:0] sh;
	logic [3:0] left;
	vtx_pkg::vtx_sym_e sym_q;

	// Symbol shifter, MSB first
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sh <= 8'h00;
			left <= 4'h0;
			sym_q <= vtx_pkg::SYM_BIT;
			eng.busy <= 1'b0;
			eng.done <= 1'b0;
			eng.lost <= 1'b0;
			eng.lost_late <= 1'b0;
			eng.first_bit <= 1'b0;
			tx_drive_o <= 1'b0;
			tx_bit_o <= 1'b0;
		end else begin
			eng.done <= 1'b0;
			eng.lost <= 1'b0;
			eng.first_bit <= 1'b0;
			if (eng.abort) begin
				eng.busy <= 1'b0;
				tx_drive_o <= 1'b0;
			end else if (eng.start && !eng.busy) begin
				eng.busy <= 1'b1;
				eng.first_bit <= 1'b1;
				sym_q <= eng.sym;
				// End of data is a passive slot
				tx_drive_o <= (eng.sym != vtx_pkg::SYM_EOD);
				case (eng.sym)
				vtx_pkg::SYM_BIT: begin
					sh <= {eng.data[0], 7'h00};
					left <= vtx_pkg::LEN_BIT;
					tx_bit_o <= eng.data[0];
				end
				vtx_pkg::SYM_BYTE: begin
					sh <= eng.data;
					left <= vtx_pkg::LEN_BYTE;
					tx_bit_o <= eng.data[7];
				end
				vtx_pkg::SYM_ONES: begin
					sh <= vtx_pkg::ONES_DATA;
					left <= vtx_pkg::LEN_ONES;
					tx_bit_o <= 1'b1;
				end
				default: begin
					sh <= 8'h00;
					left <= vtx_pkg::LEN_BIT;
					tx_bit_o <= 1'b0;
				end
				endcase
			end else if (eng.busy && eng.bit_en) begin
				// Only data bytes contend for the bus
				if (sym_q == vtx_pkg::SYM_BYTE && rx_bit_i != tx_bit_o) begin
					eng.lost <= 1'b1;
					eng.lost_late <= (left <= vtx_pkg::LATE_BITS);
					eng.busy <= 1'b0;
					tx_drive_o <= 1'b0;
				end else if (left == 4'h1) begin
					eng.done <= 1'b1;
					eng.busy <= 1'b0;
					tx_drive_o <= 1'b0;
				end else begin
					left <= left - 4'h1;
					sh <= {sh[6:0], 1'b0};
					tx_bit_o <= sh[6];
				end
			end
		end
	end
endmodule

// ### rtl/vtx_frame_tx.sv
// Transmit framing control: end of data, CRC and in-frame responses
//
// Contract
// - Polarity bit picks normalization bit per response type
// - End request: finish byte, add CRC, end symbol
// - Held byte goes out before the CRC
// - Setting end request clears buffer-empty at once
// - Main message: end request clears at CRC start
// - Response: end request clears on echoed end
// - Response requests priority encoded, readback unchanged
// - Single response: normalization bit then data byte
// - Single request clears on success, end, error
// - Requests written after end symbol stay clear
// - Lost single response retries after winner, no bit
// - Lost single response sends no extra ones
// - CRC response flags empty per byte, ends CRC
// - CRC request clears on finish, error, underrun
// - Lost multi response stops, flags, clears request
// - Lost late in multi byte sends two ones; a late loss in the CRC byte sends none
// - No-CRC response ends with end symbol only
// - No-CRC request clears on finish, error, underrun
// - Empty clears on vector read plus write
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
module vtx_frame_tx #(
	parameter int BIT_CYC = vtx_pkg::BIT_CYC
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Receiver events
	input wire logic rx_bit_i,
	input wire logic sof_rx_i,
	input wire logic eod_rx_i,
	input wire logic crc_err_i,
	input wire logic bus_err_i,
	input wire logic byte_rx_i,
	// Transmit line and receiver format
	output logic tx_drive_o,
	output logic tx_bit_o,
	output logic nb_crc_o,
	output logic nb_nocrc_o
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_NB, ST_BYTE, ST_CRC, ST_EOD, ST_ONES, ST_RETRY
	} vtx_state_e;
	typedef enum logic [1:0] {M_MAIN, M_SI, M_MC, M_MN} vtx_mode_e;
	localparam int DW = $clog2(BIT_CYC);

	vtx_eng_if eng();
	vtx_state_e st;
	vtx_mode_e mode;
	localparam int CTL_W_L = vtx_pkg::CTL_W;
	logic [CTL_W_L-1:0] ctrl;
	logic [7:0] hold;
	logic hold_full;
	logic tx_buffer_empty_flag;
	logic sv_rd;
	logic arb;
	logic frame_open;
	logic [DW-1:0] div;
	logic crc_clr;
	logic crc_upd;
	logic [7:0] crc_val;
	logic acc;
	logic wr_ctl;
	logic wr_data;
	logic rd_sv;
	logic si_e;
	logic mc_e;
	logic mn_e;
	logic eod_set;
	logic succ_si;
	logic crc_first;
	logic eod_sent;
	logic underrun;
	logic lost_ml;
	logic ifr_go;
	logic main_go;
	logic [7:0] sv_val;

	////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, then the access completes
	assign acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	assign wr_ctl = acc & avs_write_i & (avs_address_i == vtx_pkg::OFS_CTRL);
	assign wr_data = acc & avs_write_i & (avs_address_i == vtx_pkg::OFS_DATA);
	assign rd_sv = acc & avs_read_i & (avs_address_i == vtx_pkg::OFS_SV);
	assign eod_set = wr_ctl & avs_writedata_i[vtx_pkg::CTL_EOD]
		& ~ctrl[vtx_pkg::CTL_EOD];

	// Highest pending source wins the vector
	assign sv_val = arb ? vtx_pkg::SV_ARB :
		(tx_buffer_empty_flag ? vtx_pkg::SV_TX_BUFFER_EMPTY_FLAG : vtx_pkg::SV_NONE);

	// Waitrequest high by default, low for the completing cycle
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i)
				& avs_waitrequest_o);
			if (avs_read_i && avs_waitrequest_o) begin
				case (avs_address_i)
				vtx_pkg::OFS_CTRL: avs_readdata_o <= {27'h000_0000, ctrl};
				vtx_pkg::OFS_DATA: avs_readdata_o <= {24'h00_0000, hold};
				vtx_pkg::OFS_SV: avs_readdata_o <= {24'h00_0000, sv_val};
				default: avs_readdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Bit slot divider; restarts at each load so no slot is cut short
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div <= '0;
			eng.bit_en <= 1'b0;
		end else begin
			eng.bit_en <= (div == DW'(BIT_CYC - 1)) & ~(eng.start & ~eng.busy);
			div <= (eng.start & ~eng.busy) ? DW'(1)
				: ((div == DW'(BIT_CYC - 1)) ? '0 : div + 1'b1);
		end
	end

	// Effective request after priority encoding
	assign si_e = ctrl[vtx_pkg::CTL_SI];
	assign mc_e = ~ctrl[vtx_pkg::CTL_SI] & ctrl[vtx_pkg::CTL_MC];
	assign mn_e = ~ctrl[vtx_pkg::CTL_SI] & ~ctrl[vtx_pkg::CTL_MC]
		& ctrl[vtx_pkg::CTL_MNC];

	// Sequencing events
	assign succ_si = (st == ST_BYTE) & eng.done & (mode == M_SI);
	assign crc_first = (st == ST_CRC) & eng.first_bit;
	assign eod_sent = (st == ST_EOD) & eng.done;
	assign underrun = (st == ST_BYTE) & eng.done & (mode != M_SI)
		& ~hold_full & ~ctrl[vtx_pkg::CTL_EOD];
	assign lost_ml = eng.lost & (mode != M_SI);
	// A bad CRC on the echoed end symbol denies any response
	assign ifr_go = (st == ST_IDLE) & eod_rx_i & ~crc_err_i
		& (si_e | mc_e | mn_e);
	assign main_go = (st == ST_IDLE) & hold_full & ~frame_open
		& ~eod_rx_i & ~bus_err_i;

	////////////////////////////////////////////////////////////////
	// Frame window; requests only arm while a frame is open
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			frame_open <= 1'b0;
		end else if (sof_rx_i) begin
			frame_open <= 1'b1;
		end else if (eod_rx_i) begin
			frame_open <= 1'b0;
		end
	end

	// Control register: software writes, hardware clears the request and end bits
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl <= vtx_pkg::CTRL_RST;
		end else begin
			if (bus_err_i || succ_si) begin
				ctrl[vtx_pkg::CTL_SI] <= 1'b0;
			end
			if (bus_err_i || (eod_sent && mode == M_MC)
				|| (underrun && mode == M_MC)
				|| (lost_ml && mode == M_MC)) begin
				ctrl[vtx_pkg::CTL_MC] <= 1'b0;
			end
			if (bus_err_i || (eod_sent && mode == M_MN)
				|| (underrun && mode == M_MN)
				|| (lost_ml && mode == M_MN)) begin
				ctrl[vtx_pkg::CTL_MNC] <= 1'b0;
			end
			if (bus_err_i || underrun || lost_ml
				|| (crc_first && mode == M_MAIN)) begin
				ctrl[vtx_pkg::CTL_EOD] <= 1'b0;
			end else if (eod_rx_i && mode != M_MAIN
				&& (st == ST_IDLE || st == ST_EOD)) begin
				ctrl[vtx_pkg::CTL_EOD] <= 1'b0;
			end
			if (wr_ctl) begin
				// A request bit arms only while the frame is open
				for (int i = vtx_pkg::CTL_MNC; i <= vtx_pkg::CTL_SI; i++) begin
					ctrl[i] <= avs_writedata_i[i]
						& (frame_open | ctrl[i]);
				end
				if (eod_set) begin
					ctrl[vtx_pkg::CTL_SI] <= 1'b0;
				end
				ctrl[vtx_pkg::CTL_EOD] <= avs_writedata_i[vtx_pkg::CTL_EOD];
				ctrl[vtx_pkg::CTL_POL] <= avs_writedata_i[vtx_pkg::CTL_POL];
			end
		end
	end

	// Normalization bit format for the receiver
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			nb_crc_o <= 1'b1;
			nb_nocrc_o <= 1'b0;
		end else begin
			nb_crc_o <= ~ctrl[vtx_pkg::CTL_POL];
			nb_nocrc_o <= ctrl[vtx_pkg::CTL_POL];
		end
	end

	////////////////////////////////////////////////////////////////
	// Holding register; a write always refills it
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold <= 8'h00;
			hold_full <= 1'b0;
		end else if (wr_data) begin
			hold <= avs_writedata_i[7:0];
			hold_full <= 1'b1;
		end else if (eng.start && eng.sym == vtx_pkg::SYM_BYTE
			&& st == ST_BYTE && mode != M_SI) begin
			hold_full <= 1'b0;
		end else if (bus_err_i || succ_si) begin
			hold_full <= 1'b0;
		end
	end

	// Buffer-empty flag; a new load wins over a clear
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_buffer_empty_flag <= 1'b0;
			sv_rd <= 1'b0;
		end else begin
			if (eng.start && eng.sym == vtx_pkg::SYM_BYTE
				&& st == ST_BYTE && mode != M_SI) begin
				tx_buffer_empty_flag <= 1'b1;
			end else if (eod_set || bus_err_i) begin
				tx_buffer_empty_flag <= 1'b0;
			end else if (wr_data && sv_rd) begin
				tx_buffer_empty_flag <= 1'b0;
			end
			if (rd_sv && tx_buffer_empty_flag) begin
				sv_rd <= 1'b1;
			end else if (wr_data || !tx_buffer_empty_flag) begin
				sv_rd <= 1'b0;
			end
		end
	end

	// Arbitration-lost flag; vector read clears, set wins
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			arb <= 1'b0;
		end else if (lost_ml) begin
			arb <= 1'b1;
		end else if (rd_sv) begin
			arb <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Frame sequencer
	assign crc_clr = main_go | ifr_go;
	assign crc_upd = eng.start & (eng.sym == vtx_pkg::SYM_BYTE);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= ST_IDLE;
			mode <= M_MAIN;
			eng.start <= 1'b0;
			eng.abort <= 1'b0;
			eng.sym <= vtx_pkg::SYM_BIT;
			eng.data <= 8'h00;
		end else begin
			eng.start <= 1'b0;
			eng.abort <= 1'b0;
			if (bus_err_i && st != ST_IDLE) begin
				eng.abort <= 1'b1;
				st <= ST_IDLE;
			end else begin
				case (st)
				ST_IDLE: begin
					if (ifr_go) begin
						// Responses open with the normalization bit
						mode <= si_e ? M_SI : (mc_e ? M_MC : M_MN);
						eng.start <= 1'b1;
						eng.sym <= vtx_pkg::SYM_BIT;
						eng.data <= {7'h00, mc_e ? nb_crc_o : nb_nocrc_o};
						st <= ST_NB;
					end else if (main_go) begin
						mode <= M_MAIN;
						eng.start <= 1'b1;
						eng.sym <= vtx_pkg::SYM_BYTE;
						eng.data <= hold;
						st <= ST_BYTE;
					end
				end
				ST_NB: begin
					if (eng.done) begin
						eng.start <= 1'b1;
						eng.sym <= vtx_pkg::SYM_BYTE;
						eng.data <= hold;
						st <= ST_BYTE;
					end
				end
				ST_BYTE: begin
					if (eng.lost) begin
						if (mode == M_SI) begin
							st <= ST_RETRY;
						end else if (eng.lost_late) begin
							eng.start <= 1'b1;
							eng.sym <= vtx_pkg::SYM_ONES;
							st <= ST_ONES;
						end else begin
							st <= ST_IDLE;
						end
					end else if (eng.done) begin
						if (mode == M_SI) begin
							st <= ST_IDLE;
						end else if (hold_full) begin
							eng.start <= 1'b1;
							eng.sym <= vtx_pkg::SYM_BYTE;
							eng.data <= hold;
							st <= ST_BYTE;
						end else if (ctrl[vtx_pkg::CTL_EOD]) begin
							eng.start <= 1'b1;
							if (mode == M_MN) begin
								eng.sym <= vtx_pkg::SYM_EOD;
								st <= ST_EOD;
							end else begin
								eng.sym <= vtx_pkg::SYM_BYTE;
								eng.data <= crc_val;
								st <= ST_CRC;
							end
						end else begin
							// Underrun: two ones force a boundary fault
							eng.start <= 1'b1;
							eng.sym <= vtx_pkg::SYM_ONES;
							st <= ST_ONES;
						end
					end
				end
				ST_CRC: begin
					if (eng.lost) begin
						st <= ST_IDLE;
					end else if (eng.done) begin
						eng.start <= 1'b1;
						eng.sym <= vtx_pkg::SYM_EOD;
						st <= ST_EOD;
					end
				end
				ST_RETRY: begin
					// Wait for the winning byte, resend without the bit
					if (!si_e) begin
						st <= ST_IDLE;
					end else if (byte_rx_i) begin
						eng.start <= 1'b1;
						eng.sym <= vtx_pkg::SYM_BYTE;
						eng.data <= hold;
						st <= ST_BYTE;
					end
				end
				ST_EOD, ST_ONES: begin
					if (eng.done) begin
						st <= ST_IDLE;
					end
				end
				default: st <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Leaf blocks
	vtx_crc8 u_crc (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.clr_i(crc_clr),
		.upd_i(crc_upd),
		.data_i(eng.data),
		.crc_o(crc_val)
	);

	vtx_bit_engine u_eng (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.rx_bit_i(rx_bit_i),
		.eng(eng.eng),
		.tx_drive_o(tx_drive_o),
		.tx_bit_o(tx_bit_o)
	);
endmodule

// ### tb/vtx_frame_tx_asserts.sv
// Port assertions for the frame transmit control
`timescale 1ns/10ps
module vtx_frame_tx_asserts #(
	parameter int BIT_CYC = 8
) (
	// Clock, reset and slave bus
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Line side
	input wire logic bus_err_i,
	input wire logic tx_drive_o,
	input wire logic nb_crc_o,
	input wire logic nb_nocrc_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	logic pol_w;
	logic rd_ack;
	logic unmapped;
	wire wr_ctl = avs_write_i && !avs_waitrequest_o
		&& avs_address_i == vtx_pkg::OFS_CTRL;
	assign rd_ack = avs_read_i && !avs_waitrequest_o;
	assign unmapped = avs_address_i != vtx_pkg::OFS_CTRL
		&& avs_address_i != vtx_pkg::OFS_DATA
		&& avs_address_i != vtx_pkg::OFS_SV;
	// Polarity as last accepted, to judge the format outputs against
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			pol_w <= 1'b0;
		else if (wr_ctl)
			pol_w <= avs_writedata_i[vtx_pkg::CTL_POL];
	end
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ack;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	chk_one_wait: assert property (s_req |=> s_ack)
		else $error("bus answer not after one wait state");
	chk_ack_has_req: assert property (!avs_waitrequest_o
		|-> $past(avs_read_i || avs_write_i))
		else $error("bus answer without a request");
	chk_unmapped_zero: assert property (rd_ack && unmapped
		|-> avs_readdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (rd_ack
		|-> avs_readdata_o[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	chk_pol_follow: assert property (
		wr_ctl |=> ##[0:1] nb_crc_o == !pol_w)
		else $error("format bit does not follow polarity");
	chk_nb_opposite: assert property (
		nb_crc_o != nb_nocrc_o)
		else $error("both format bits equal");
	chk_err_stops: assert property (
		bus_err_i |-> ##[1:3] !tx_drive_o)
		else $error("line still driven after bus error");
endmodule

// ### tb/vtx_bus_node.sv
// Far-side bus node: line echo, arbitration loss and receiver events
`timescale 1ns/10ps
module vtx_bus_node #(
	parameter int BIT_CYC = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Line from the transmitter and loss command
	input wire logic tx_drive_i,
	input wire logic tx_bit_i,
	input wire logic lose_i,
	// Level and events toward the transmitter
	output logic rx_bit_o,
	output logic sof_o,
	output logic eod_o,
	output logic crc_err_o,
	output logic bus_err_o,
	output logic byte_o
);
	int cnt;
	int nbits;
	logic [63:0] bits;
	// A winning node shows the other value; a released line is pulled low
	assign rx_bit_o = tx_drive_i ? (tx_bit_i ^ lose_i) : 1'b0;
	initial begin
		byte_o = 1'b0;
		sof_o = 1'b0;
		eod_o = 1'b0;
		crc_err_o = 1'b0;
		bus_err_o = 1'b0;
	end
	// Sample each driven slot in its middle, away from the edges
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 0;
			nbits <= 0;
			bits <= '0;
		end else if (!tx_drive_i) begin
			cnt <= 0;
		end else begin
			cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
			if (cnt == BIT_CYC / 2) begin
				bits <= {bits[62:0], tx_bit_i};
				nbits <= nbits + 1;
			end
		end
	end
	// One-cycle event: 0 frame start, 1 good end, 2 bad end, 3 bus error,
	// 4 winning byte done
	task automatic pulse(input int which);
		@(posedge ref_clk_i);
		byte_o <= which == 4;
		sof_o <= which == 0;
		eod_o <= which == 1 || which == 2;
		crc_err_o <= which == 2;
		bus_err_o <= which == 3;
		@(posedge ref_clk_i);
		byte_o <= 1'b0;
		sof_o <= 1'b0;
		eod_o <= 1'b0;
		crc_err_o <= 1'b0;
		bus_err_o <= 1'b0;
	endtask
endmodule

// ### tb/vtx_frame_tx_tb.sv
// Self-checking bench for the frame transmit control
`timescale 1ns/10ps
module vtx_frame_tx_tb;
	localparam int BC = 8;
	logic ref_clk_i, rstn_i, rd, wr, waitreq, lose;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, rv;
	logic rx_bit, sof, eod, crc_err, bus_err, byte_rx;
	logic tx_drive, tx_bit, nb_crc, nb_nocrc;
	int bad_count, compares, cycles, n0;
	vtx_frame_tx #(.BIT_CYC(BC)) u_vtx_frame_tx (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .rx_bit_i(rx_bit), .sof_rx_i(sof),
		.eod_rx_i(eod), .crc_err_i(crc_err), .bus_err_i(bus_err),
		.byte_rx_i(byte_rx), .tx_drive_o(tx_drive), .tx_bit_o(tx_bit),
		.nb_crc_o(nb_crc), .nb_nocrc_o(nb_nocrc));
	vtx_bus_node #(.BIT_CYC(BC)) u_vtx_bus_node (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .tx_drive_i(tx_drive),
		.tx_bit_i(tx_bit), .lose_i(lose), .rx_bit_o(rx_bit), .sof_o(sof),
		.eod_o(eod), .crc_err_o(crc_err), .bus_err_o(bus_err),
		.byte_o(byte_rx));
	////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the run needs about a thousand cycles
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic fail(input string m);
		bad_count++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task automatic chk_reg(input logic [31:0] got, exp, input string m);
		compares++;
		if (got !== exp)
			fail(m);
	endtask
	task automatic chk_pin(input logic got, exp, input string m);
		compares++;
		if (got !== exp)
			fail(m);
	endtask
	// One slave access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= {24'h00_0000, d};
		// Only the bench timeout ends this wait
		do begin
			@(posedge ref_clk_i);
		end while (waitreq !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk_reg(rv, {24'h00_0000, e}, "register read");
	endtask
	// Poll the vector until it shows the expected code
	task automatic wait_sv(input logic [7:0] e);
		int k;
		k = 0;
		do begin
			bus(1'b0, vtx_pkg::OFS_SV, 8'h00);
			k++;
		end while (rv !== {24'h00_0000, e} && k < 20);
		chk_reg(rv, {24'h00_0000, e}, "state vector");
	endtask
	// Line idle for three slots means the frame has ended
	task automatic settle;
		int q, n;
		q = 0;
		n = 0;
		while (q < 3 * BC && n < 3000) begin
			@(posedge ref_clk_i);
			n++;
			q = tx_drive ? 0 : q + 1;
		end
		if (n >= 3000)
			fail("line never idle");
	endtask
	task automatic chk_line(input int cnt, input logic [31:0] v);
		chk_reg(u_vtx_bus_node.nbits - n0, cnt, "bit count");
		chk_reg(u_vtx_bus_node.bits[31:0] & ((32'h1 << cnt) - 1), v,
			"line bits");
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = vtx_pkg::CRC_INIT ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? {c[6:0], 1'b0} ^ vtx_pkg::CRC_POLY : {c[6:0], 1'b0};
		return ~c;
	endfunction
	task automatic respond(input logic [7:0] d, ctl, input int ev);
		u_vtx_bus_node.pulse(0);
		bus(1'b1, vtx_pkg::OFS_DATA, d);
		bus(1'b1, vtx_pkg::OFS_CTRL, ctl);
		n0 = u_vtx_bus_node.nbits;
		u_vtx_bus_node.pulse(ev);
	endtask
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rd, wr, lose, addr, wdata, bad_count, compares, cycles} = '0;
		rstn_i = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		rd_chk(vtx_pkg::OFS_CTRL, 8'h00);
		rd_chk(vtx_pkg::OFS_SV, vtx_pkg::SV_NONE);
		bus(1'b1, 4'hc, 8'hff);
		rd_chk(4'hc, 8'h00);
		$display("test reset and map done");
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, vtx_pkg::OFS_CTRL, 8'(p << 4));
			rd_chk(vtx_pkg::OFS_CTRL, 8'(p << 4));
			chk_pin(nb_crc, !p[0], "crc format bit");
			chk_pin(nb_nocrc, p[0], "plain format bit");
		end
		bus(1'b1, vtx_pkg::OFS_CTRL, 8'h07);
		rd_chk(vtx_pkg::OFS_CTRL, 8'h00);
		$display("test polarity and closed frame done");
		n0 = u_vtx_bus_node.nbits;
		bus(1'b1, vtx_pkg::OFS_DATA, 8'ha5);
		wait_sv(vtx_pkg::SV_TX_BUFFER_EMPTY_FLAG);
		bus(1'b1, vtx_pkg::OFS_CTRL, 8'h08);
		rd_chk(vtx_pkg::OFS_SV, vtx_pkg::SV_NONE);
		settle();
		chk_line(16, {16'h0000, 8'ha5, crc8(8'ha5)});
		rd_chk(vtx_pkg::OFS_CTRL, 8'h00);
		$display("test main message done");
		respond(8'h5a, 8'h03, 1);
		rd_chk(vtx_pkg::OFS_CTRL, 8'h03);
		wait_sv(vtx_pkg::SV_TX_BUFFER_EMPTY_FLAG);
		bus(1'b1, vtx_pkg::OFS_CTRL, 8'h0a);
		settle();
		rd_chk(vtx_pkg::OFS_SV, vtx_pkg::SV_NONE);
		chk_line(17, {15'h0000, 1'b1, 8'h5a, crc8(8'h5a)});
		rd_chk(vtx_pkg::OFS_CTRL, 8'h08);
		u_vtx_bus_node.pulse(1);
		rd_chk(vtx_pkg::OFS_CTRL, 8'h00);
		$display("test crc response done");
		respond(8'h3c, 8'h14, 1);
		settle();
		chk_line(9, {23'h00_0000, 1'b1, 8'h3c});
		rd_chk(vtx_pkg::OFS_CTRL, 8'h10);
		// No data loaded here, so no main message follows the bad end
		u_vtx_bus_node.pulse(0);
		bus(1'b1, vtx_pkg::OFS_CTRL, 8'h14);
		n0 = u_vtx_bus_node.nbits;
		u_vtx_bus_node.pulse(2);
		settle();
		chk_line(0, 32'h0000_0000);
		bus(1'b1, vtx_pkg::OFS_CTRL, 8'h00);
		$display("test single response done");
		respond(8'h12, 8'h01, 1);
		wait_sv(vtx_pkg::SV_TX_BUFFER_EMPTY_FLAG);
		bus(1'b1, vtx_pkg::OFS_DATA, 8'h34);
		bus(1'b1, vtx_pkg::OFS_CTRL, 8'h09);
		settle();
		chk_line(17, {15'h0000, 1'b0, 8'h12, 8'h34});
		rd_chk(vtx_pkg::OFS_CTRL, 8'h08);
		u_vtx_bus_node.pulse(1);
		rd_chk(vtx_pkg::OFS_CTRL, 8'h00);
		$display("test no-crc response done");
		respond(8'h81, 8'h01, 1);
		u_vtx_bus_node.pulse(3);
		settle();
		rd_chk(vtx_pkg::OFS_CTRL, 8'h00);
		lose <= 1'b1;
		respond(8'hc3, 8'h02, 1);
		settle();
		lose <= 1'b0;
		rd_chk(vtx_pkg::OFS_SV, vtx_pkg::SV_ARB);
		rd_chk(vtx_pkg::OFS_CTRL, 8'h00);
		$display("test error and loss done");
		lose <= 1'b1;
		respond(8'h96, 8'h04, 1);
		repeat (3 * BC) @(posedge ref_clk_i);
		lose <= 1'b0;
		n0 = u_vtx_bus_node.nbits;
		u_vtx_bus_node.pulse(4);
		settle();
		chk_line(8, {24'h00_0000, 8'h96});
		rd_chk(vtx_pkg::OFS_CTRL, 8'h00);
		$display("test single retry done");
		close_out();
	end
endmodule
bind vtx_frame_tx vtx_frame_tx_asserts #(.BIT_CYC(BIT_CYC))
	u_vtx_frame_tx_asserts (
	.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.bus_err_i(bus_err_i), .tx_drive_o(tx_drive_o),
	.nb_crc_o(nb_crc_o), .nb_nocrc_o(nb_nocrc_o));
